// ---- hdl/afecrb_pkg.sv ----
// Purpose: constants for the front-end control register bank
// Assumes: 100 MHz pixel clock, synchronous active-low reset
// Notes:   one place for every offset, field and reset value
// Operation
// [RULE1] config bit 0: input clamp polarity
// [RULE2] config bit 1: black clamp polarity
// [RULE3] config bit 2: sample pulse polarity
// [RULE4] config bit 4: channel output order
// [RULE5] config bits 7:6: output data delay
// [RULE6] reg 01h bit 0: standby select
// [RULE7] reg 01h bits 5:2: second edge delay
// [RULE8] reg 01h bits 9:6: first edge delay
// [RULE9] host keeps first edge before second
// [RULE10] reg 07h bit 1: clock onto lsb
// [RULE11] regs 02h/03h: gain code over 64
// [RULE12] regs 04h/05h: clamp code times two
// [RULE13] reg 06h bit 0: test pattern enable
// [RULE14] reg 06h bit 2: stripe or gradation
// [RULE15] reg 06h bits 5:4: pattern interval
// [RULE16] readback picks register by A[2:0]
// [RULE17] shift on sclk rise, latch on strobe
// [RULE18] 16-bit frame, chip address must match
// [RULE19] A3 set means read, writes blocked
// [RULE20] stripe black+128, gradation ramps to 4095
// [RULE21] unassigned bits ignored, read zero
package afecrb_pkg;
    //----------------------------------------------------------------
    // frame layout
    //----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS  = 10;
    localparam int CHIP_HI    = 15;
    localparam int CHIP_LO    = 14;
    localparam int READ_BIT   = 13;
    localparam int ADDR_HI    = 12;
    localparam int ADDR_LO    = 10;
    //----------------------------------------------------------------
    // register indices
    //----------------------------------------------------------------
    localparam logic [2:0] REG_CONFIG  = 3'h0;
    localparam logic [2:0] REG_STANDBY = 3'h1;
    localparam logic [2:0] REG_GAIN_EV = 3'h2;
    localparam logic [2:0] REG_GAIN_OD = 3'h3;
    localparam logic [2:0] REG_CLMP_EV = 3'h4;
    localparam logic [2:0] REG_CLMP_OD = 3'h5;
    localparam logic [2:0] REG_TEST    = 3'h6;
    localparam logic [2:0] REG_PROBE   = 3'h7;
    //----------------------------------------------------------------
    // writable bit masks, unlisted bits read zero
    //----------------------------------------------------------------
    localparam logic [9:0] MASK_CONFIG  = 10'h0d7;
    localparam logic [9:0] MASK_STANDBY = 10'h3fd;
    localparam logic [9:0] MASK_GAIN    = 10'h3ff;
    localparam logic [9:0] MASK_CLAMP   = 10'h0ff;
    localparam logic [9:0] MASK_TEST    = 10'h035;
    localparam logic [9:0] MASK_PROBE   = 10'h002;
    //----------------------------------------------------------------
    // reset values
    //----------------------------------------------------------------
    localparam logic [9:0] RST_CONFIG  = 10'h000;
    localparam logic [9:0] RST_STANDBY = 10'h220;
    localparam logic [9:0] RST_GAIN    = 10'h040;
    localparam logic [9:0] RST_CLAMP   = 10'h050;
    localparam logic [9:0] RST_TEST    = 10'h000;
    localparam logic [9:0] RST_PROBE   = 10'h000;
    //----------------------------------------------------------------
    // field positions
    //----------------------------------------------------------------
    localparam int F_IN_CLAMP  = 0;
    localparam int F_BLK_CLAMP = 1;
    localparam int F_SAMPLE    = 2;
    localparam int F_ORDER     = 4;
    localparam int F_DLY_LO    = 6;
    localparam int F_STANDBY   = 0;
    localparam int F_EDGE2_LO  = 2;
    localparam int F_EDGE1_LO  = 6;
    localparam int F_TEST_EN   = 0;
    localparam int F_TEST_SEL  = 2;
    localparam int F_INTV_LO   = 4;
    localparam int F_PROBE     = 1;
    //----------------------------------------------------------------
    // test pattern constants
    //----------------------------------------------------------------
    localparam logic [11:0] STRIPE_LIFT = 12'h080;
    localparam logic [11:0] GRAD_TOP    = 12'hfff;
    localparam logic [11:0] GRAD_START  = 12'h001;
    localparam logic [6:0]  STRIPE_BASE = 7'h08;
    localparam logic [6:0]  GRAD_BASE   = 7'h02;
endpackage

// ---- hdl/afecrb_pattern.sv ----
// Purpose: test pattern source for one output stream
// Assumes: one pixel per clk_i cycle while enabled
// Notes:   interval counter shared by stripe and gradation
`timescale 1ns/1ps
`default_nettype none
module afecrb_pattern (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        enable_i,
    input  wire logic        stripe_i,
    input  wire logic [1:0]  interval_i,
    input  wire logic [7:0]  black_code_i,
    output logic      [11:0] pattern_o
);
    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    typedef struct packed {
        logic [6:0]  count;   // pixels in current interval
        logic        phase;   // stripe high or low half
        logic [11:0] value;   // pattern word out
    } afecrb_pat_s;
    afecrb_pat_s st, next_st;
    logic [6:0]  span;        // pixels per interval
    logic [11:0] black;       // clamp level in lsb
    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        next_st = st;
        span  = (stripe_i ? afecrb_pkg::STRIPE_BASE
                          : afecrb_pkg::GRAD_BASE) << interval_i; // RULE15
        black = {3'h0, black_code_i, 1'b0};                       // RULE12
        if (!enable_i) begin
            // restart cleanly each time test mode is entered
            next_st.count = 7'h00;
            next_st.phase = 1'b0;
            next_st.value = afecrb_pkg::GRAD_START;
        end else begin
            // at or past the end: a shorter interval must not stall
            if (st.count >= span - 7'h01) begin
                next_st.count = 7'h00;
                next_st.phase = ~st.phase;
                if (!stripe_i) begin
                    // ramp wraps back to one after the top code
                    if (st.value == afecrb_pkg::GRAD_TOP) begin
                        next_st.value = afecrb_pkg::GRAD_START; // RULE20
                    end else begin
                        next_st.value = st.value + 12'h001;     // RULE20
                    end
                end
            end else begin
                next_st.count = st.count + 7'h01;
            end
            if (stripe_i) begin
                next_st.value = next_st.phase
                              ? black + afecrb_pkg::STRIPE_LIFT : black; // RULE20
            end
        end
    end
    //----------------------------------------------------------------
    // registers
    //----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '{count: 7'h00, phase: 1'b0, value: 12'h001};
        end else begin
            st <= next_st;
        end
    end
    assign pattern_o = st.value;
    a_grad_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (enable_i && !stripe_i) |=> (st.value != 12'h000)) // RULE20
        else $error("gradation reached zero");
    c_stripe_on: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        enable_i && stripe_i && st.phase);
endmodule
`default_nettype wire

// ---- hdl/afecrb_top.sv ----
// Purpose: control register bank behind a three-wire serial port
// Assumes: serial pins are asynchronous to the pixel clock
// Notes:   sclk and strobe are sampled, so they must be slow
`timescale 1ns/1ps
`default_nettype none
module afecrb_top (
    input  wire logic        CLOCK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        SERIAL_CLOCK_I,
    input  wire logic        SERIAL_IN_I,
    input  wire logic        WRITE_LATCH_STROBE_I,
    input  wire logic        CHIP_SELECT_PIN_LOW_I,
    input  wire logic        CHIP_SELECT_PIN_HIGH_I,
    input  wire logic        CONVERTER_CLOCK_I,
    input  wire logic [11:0] CONVERTER_DATA_I,
    output logic             READBACK_OUT_O,
    output logic             INPUT_CLAMP_ACTIVE_HIGH_O,
    output logic             BLACK_CLAMP_ACTIVE_HIGH_O,
    output logic             SAMPLE_PULSE_ACTIVE_HIGH_O,
    output logic             ODD_FIRST_O,
    output logic      [1:0]  OUTPUT_DELAY_O,
    output logic             STANDBY_O,
    output logic      [3:0]  EDGE2_DELAY_O,
    output logic      [3:0]  EDGE1_DELAY_O,
    output logic      [9:0]  EVEN_GAIN_O,
    output logic      [9:0]  ODD_GAIN_O,
    output logic      [7:0]  EVEN_CLAMP_O,
    output logic      [7:0]  ODD_CLAMP_O,
    output logic      [11:0] OUTPUT_DATA_O
);
    //----------------------------------------------------------------
    // pin synchronisers, three stages each
    //----------------------------------------------------------------
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pins;
    assign pins = {CONVERTER_CLOCK_I, WRITE_LATCH_STROBE_I,
                   SERIAL_IN_I, SERIAL_CLOCK_I};
    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    typedef struct packed {
        logic [NSYNC-1:0] sy1;    // first sync stage, feeds sy2 only
        logic [NSYNC-1:0] sy2;    // second sync stage
        logic [NSYNC-1:0] sy3;    // third sync stage
        logic [15:0]  shreg;      // incoming serial frame
        logic [9:0]   rdshift;    // outgoing readback word
        logic         reading;    // readback in progress
        logic         sclk_q;     // filtered sclk level
        logic         wrt_q;      // filtered strobe level
        logic         sdi_q;      // filtered data level
        logic         converter_clock_q;     // filtered converter clock
        logic [9:0]   r0, r1, r2, r3, r4, r5, r6, r7;
        logic         readback_out;        // readback pin
        logic [11:0]  dout;       // data pins
    } afecrb_st_s;
    afecrb_st_s st, next_st;
    logic [11:0] pattern;         // test pattern word
    logic        sclk_rise;       // debounced sclk rising edge
    logic        wrt_rise;        // debounced strobe rising edge
    logic        chip_hit;        // frame chip address matches
    logic [2:0]  addr;            // frame register index
    logic [9:0]  wdata;           // frame data field
    logic [11:0] mux_data;        // converter or pattern data
    //----------------------------------------------------------------
    // register read; unassigned bits are already zero from the write masks
    //----------------------------------------------------------------
    function automatic logic [9:0] rd_reg(input afecrb_st_s s,
                                          input logic [2:0] a);
        case (a)
            afecrb_pkg::REG_CONFIG:  rd_reg = s.r0;
            afecrb_pkg::REG_STANDBY: rd_reg = s.r1;
            afecrb_pkg::REG_GAIN_EV: rd_reg = s.r2;
            afecrb_pkg::REG_GAIN_OD: rd_reg = s.r3;
            afecrb_pkg::REG_CLMP_EV: rd_reg = s.r4;
            afecrb_pkg::REG_CLMP_OD: rd_reg = s.r5;
            afecrb_pkg::REG_TEST:    rd_reg = s.r6;
            default:                 rd_reg = s.r7;
        endcase
    endfunction
    //----------------------------------------------------------------
    // decode and edges; a change counts when stages 2 and 3 agree
    //----------------------------------------------------------------
    assign sclk_rise = st.sy2[0] && st.sy3[0] && !st.sclk_q;        // RULE17
    assign wrt_rise  = st.sy2[2] && st.sy3[2] && !st.wrt_q;         // RULE17
    assign chip_hit  = st.shreg[afecrb_pkg::CHIP_HI] == CHIP_SELECT_PIN_HIGH_I
                    && st.shreg[afecrb_pkg::CHIP_LO] == CHIP_SELECT_PIN_LOW_I;
    assign addr  = st.shreg[afecrb_pkg::ADDR_HI:afecrb_pkg::ADDR_LO];
    assign wdata = st.shreg[afecrb_pkg::DATA_BITS-1:0];
    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // filtered levels move only when two stages agree
        next_st.sy1 = pins;
        next_st.sy2 = st.sy1;
        next_st.sy3 = st.sy2;
        if (st.sy2[0] == st.sy3[0]) next_st.sclk_q = st.sy3[0];
        if (st.sy2[1] == st.sy3[1]) next_st.sdi_q  = st.sy3[1];
        if (st.sy2[2] == st.sy3[2]) next_st.wrt_q  = st.sy3[2];
        if (st.sy2[3] == st.sy3[3]) next_st.converter_clock_q = st.sy3[3];
        // serial shift; while reading the same clock drives readback
        if (sclk_rise) begin
            next_st.shreg = {st.shreg[14:0], st.sdi_q};             // RULE17
            if (st.reading) begin
                next_st.readback_out     = st.rdshift[9];                    // RULE16
                next_st.rdshift = {st.rdshift[8:0], 1'b0};
            end
        end
        if (wrt_rise && chip_hit) begin                             // RULE18
            if (st.shreg[afecrb_pkg::READ_BIT]) begin
                // read command: load word, block writes until a write
                next_st.reading = 1'b1;                             // RULE19
                next_st.rdshift = rd_reg(st, addr);                 // RULE16
                next_st.readback_out     = 1'b0;
            end else if (!st.reading) begin                         // RULE19
                case (addr)
                    afecrb_pkg::REG_CONFIG:
                        next_st.r0 = wdata & afecrb_pkg::MASK_CONFIG;  // RULE21
                    afecrb_pkg::REG_STANDBY:
                        next_st.r1 = wdata & afecrb_pkg::MASK_STANDBY; // RULE21
                    afecrb_pkg::REG_GAIN_EV:
                        next_st.r2 = wdata & afecrb_pkg::MASK_GAIN;    // RULE11
                    afecrb_pkg::REG_GAIN_OD:
                        next_st.r3 = wdata & afecrb_pkg::MASK_GAIN;    // RULE11
                    afecrb_pkg::REG_CLMP_EV:
                        next_st.r4 = wdata & afecrb_pkg::MASK_CLAMP;   // RULE12
                    afecrb_pkg::REG_CLMP_OD:
                        next_st.r5 = wdata & afecrb_pkg::MASK_CLAMP;   // RULE12
                    afecrb_pkg::REG_TEST:
                        next_st.r6 = wdata & afecrb_pkg::MASK_TEST;    // RULE21
                    default:
                        next_st.r7 = wdata & afecrb_pkg::MASK_PROBE;   // RULE21
                endcase
            end else begin
                // first write frame after a read only ends the read
                next_st.reading = 1'b0;                             // RULE19
            end
        end
        // data pins: test pattern replaces converter data
        mux_data = st.r6[afecrb_pkg::F_TEST_EN]
                 ? pattern : CONVERTER_DATA_I;                      // RULE13
        if (st.r7[afecrb_pkg::F_PROBE]) begin
            mux_data[0] = st.converter_clock_q;                                // RULE10
        end
        next_st.dout = mux_data;
    end
    //----------------------------------------------------------------
    // registers
    //----------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            st  <= '0;
            st.r0 <= afecrb_pkg::RST_CONFIG;
            st.r1 <= afecrb_pkg::RST_STANDBY;
            st.r2 <= afecrb_pkg::RST_GAIN;
            st.r3 <= afecrb_pkg::RST_GAIN;
            st.r4 <= afecrb_pkg::RST_CLAMP;
            st.r5 <= afecrb_pkg::RST_CLAMP;
            st.r6 <= afecrb_pkg::RST_TEST;
            st.r7 <= afecrb_pkg::RST_PROBE;
        end else begin
            st  <= next_st;
        end
    end
    //----------------------------------------------------------------
    // test pattern generator, even channel clamp as black level
    //----------------------------------------------------------------
    afecrb_pattern u_pattern (
        .clk_i        (CLOCK_I),
        .rst_n_i      (RESET_N_I),
        .enable_i     (st.r6[afecrb_pkg::F_TEST_EN]),               // RULE13
        .stripe_i     (st.r6[afecrb_pkg::F_TEST_SEL]),              // RULE14
        .interval_i   (st.r6[afecrb_pkg::F_INTV_LO +: 2]),          // RULE15
        .black_code_i (st.r4[7:0]),
        .pattern_o    (pattern)
    );
    //----------------------------------------------------------------
    // field outputs, all straight from the register flops
    //----------------------------------------------------------------
    assign INPUT_CLAMP_ACTIVE_HIGH_O  = st.r0[afecrb_pkg::F_IN_CLAMP];  // RULE1
    assign BLACK_CLAMP_ACTIVE_HIGH_O  = st.r0[afecrb_pkg::F_BLK_CLAMP]; // RULE2
    assign SAMPLE_PULSE_ACTIVE_HIGH_O = st.r0[afecrb_pkg::F_SAMPLE];    // RULE3
    assign ODD_FIRST_O    = st.r0[afecrb_pkg::F_ORDER];                 // RULE4
    assign OUTPUT_DELAY_O = st.r0[afecrb_pkg::F_DLY_LO +: 2];           // RULE5
    assign STANDBY_O      = st.r1[afecrb_pkg::F_STANDBY];               // RULE6
    assign EDGE2_DELAY_O  = st.r1[afecrb_pkg::F_EDGE2_LO +: 4];         // RULE7
    assign EDGE1_DELAY_O  = st.r1[afecrb_pkg::F_EDGE1_LO +: 4];         // RULE8
    assign EVEN_GAIN_O    = st.r2;                                      // RULE11
    assign ODD_GAIN_O     = st.r3;                                      // RULE11
    assign EVEN_CLAMP_O   = st.r4[7:0];                                 // RULE12
    assign ODD_CLAMP_O    = st.r5[7:0];                                 // RULE12
    assign READBACK_OUT_O = st.readback_out;
    assign OUTPUT_DATA_O  = st.dout;
    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    a_write_block: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        st.reading |=> $stable(st.r2)) // RULE19
        else $error("gain changed during read");
    a_chip_gate: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        (wrt_rise && !chip_hit) |=> $stable(st.r0) && $stable(st.r6)) // RULE18
        else $error("write to foreign chip address");
    a_cfg_zeros: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        (st.r0 & ~afecrb_pkg::MASK_CONFIG) == 10'h000) // RULE21
        else $error("config reserved bit set");
    a_probe_lsb: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        st.r7[1] |=> OUTPUT_DATA_O[0] == $past(st.converter_clock_q)) // RULE10
        else $error("probe not on lsb");
    a_read_load: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        (wrt_rise && chip_hit && st.shreg[13]) |=> st.reading) // RULE16
        else $error("read not started");
    a_shift_in: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        sclk_rise |=> st.shreg[0] == $past(st.sdi_q)) // RULE17
        else $error("serial bit not shifted");
    a_gain_write: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        (wrt_rise && chip_hit && !st.reading && st.shreg[13:10] == 4'h2)
        |=> EVEN_GAIN_O == $past(wdata)) // RULE11
        else $error("gain write lost");
    a_standby_wr: assert property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        (wrt_rise && chip_hit && !st.reading && st.shreg[13:10] == 4'h1)
        |=> STANDBY_O == $past(wdata[0])) // RULE6
        else $error("standby write lost");
    c_write: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        wrt_rise && chip_hit && !st.shreg[13]);
    c_read: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        st.reading && sclk_rise);
    c_test: cover property (@(posedge CLOCK_I) disable iff (!RESET_N_I)
        st.r6[0]);
endmodule
`default_nettype wire

// ---- sim/afecrb_host.sv ----
// Purpose: host model driving the three-wire serial port
// Assumes: every pin level lasts PH pixel clocks
// Notes:   sclk idles low; data line flips when no bit is due
`timescale 1ns/1ps
`default_nettype none
module afecrb_host (
    input  wire logic clk_i,
    input  wire logic readback_i,
    output logic      sclk_o,
    output logic      sdi_o,
    output logic      strobe_o
);
    //------------------------------------------------------------
    // serial frame tasks
    //------------------------------------------------------------
    localparam int PH = 6; // pins are sampled, so keep levels long
    initial begin
        sclk_o   = 1'b0;
        sdi_o    = 1'b0;
        strobe_o = 1'b0;
    end
    // wait n pixel clocks
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one serial clock pulse
    task automatic pulse;
        hold(PH);
        sclk_o <= 1'b1;
        hold(PH);
        sclk_o <= 1'b0;
    endtask
    // sixteen bits msb first, then the latch strobe
    task automatic frame(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) begin
            sdi_o <= f[i];
            pulse;
        end
        sdi_o <= ~f[0];
        hold(PH);
        strobe_o <= 1'b1;
        hold(PH);
        strobe_o <= 1'b0;
        hold(PH);
    endtask
    // read frame, then ten pulses bring the register out
    task automatic read(input logic [1:0] ch, input logic [2:0] a,
                        output logic [9:0] d);
        frame({ch, 1'b1, a, 10'h000});
        for (int i = 9; i >= 0; i--) begin
            sdi_o <= ~sdi_o;
            pulse;
            d[i] = readback_i; // bit stands until next pulse
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the control register bank
// Assumes: straps fixed, converter clock stepped by the bench
// Notes:   every host write keeps edge 1 equal to edge 2
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    //------------------------------------------------------------
    // signals
    //------------------------------------------------------------
    localparam logic [1:0] CHIP = 2'h2; // strap value
    logic        clk, rst_n, sclk, serial_in, stb, rbo, icl, bcl, smp, odd, sby;
    logic        converter_clock;         // converter clock pin
    logic [1:0]  dly;
    logic [3:0]  e2, e1;
    logic [9:0]  g_ev, g_od, d;
    logic [7:0]  c_ev, c_od;
    logic [11:0] dout, v;
    logic [9:0]  ex [8];
    logic [9:0]  mk [8];
    int          n_errors = 0;
    int          compares = 0;
    int          run, lim;
    afecrb_top afecrb_top_inst (.CLOCK_I(clk), .RESET_N_I(rst_n),
        .SERIAL_CLOCK_I(sclk), .SERIAL_IN_I(serial_in),
        .WRITE_LATCH_STROBE_I(stb), .CHIP_SELECT_PIN_LOW_I(CHIP[0]),
        .CHIP_SELECT_PIN_HIGH_I(CHIP[1]), .CONVERTER_CLOCK_I(converter_clock),
        .CONVERTER_DATA_I(12'h5a4), .READBACK_OUT_O(rbo),
        .INPUT_CLAMP_ACTIVE_HIGH_O(icl), .BLACK_CLAMP_ACTIVE_HIGH_O(bcl),
        .SAMPLE_PULSE_ACTIVE_HIGH_O(smp), .ODD_FIRST_O(odd),
        .OUTPUT_DELAY_O(dly), .STANDBY_O(sby), .EDGE2_DELAY_O(e2),
        .EDGE1_DELAY_O(e1), .EVEN_GAIN_O(g_ev), .ODD_GAIN_O(g_od),
        .EVEN_CLAMP_O(c_ev), .ODD_CLAMP_O(c_od), .OUTPUT_DATA_O(dout));
    afecrb_host afecrb_host_inst (.clk_i(clk), .readback_i(rbo),
        .sclk_o(sclk), .sdi_o(serial_in), .strobe_o(stb));
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    // expected image follows only frames that match the straps
    task automatic wr(input logic [1:0] ch, input logic [2:0] a,
                      input logic [9:0] x);
        afecrb_host_inst.frame({ch, 1'b0, a, x});
        if (ch == CHIP) ex[a] = x & mk[a];
    endtask
    // read every register; the frame after a read must not write
    task automatic rd_all;
        for (int a = 0; a < 8; a++) begin
            afecrb_host_inst.read(CHIP, a[2:0], d);
            `CHK("readback", ex[a], d)
            afecrb_host_inst.frame({CHIP, 4'h2, ~ex[2]});
            `CHK("gain after read", ex[2], g_ev)
        end
    endtask
    // field outputs against the expected image
    task automatic chk_ports;
        `CHK("in clamp", ex[0][0], icl)
        `CHK("blk clamp", ex[0][1], bcl)
        `CHK("sample", ex[0][2], smp)
        `CHK("order", ex[0][4], odd)
        `CHK("delay", ex[0][7:6], dly)
        `CHK("standby", ex[1][0], sby)
        `CHK("edge2", ex[1][5:2], e2)
        `CHK("edge1", ex[1][9:6], e1)
        `CHK("gain ev", ex[2], g_ev)
        `CHK("gain od", ex[3], g_od)
        `CHK("clamp ev", ex[4][7:0], c_ev)
        `CHK("clamp od", ex[5][7:0], c_od)
    endtask
    // verdict, reached by the tests or the watchdog
    task automatic summarize;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    //------------------------------------------------------------
    // clock, watchdog, tests
    //------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // tests take about 26k clocks
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        summarize;
    end
    initial begin
        rst_n = 1'b0;
        converter_clock <= 1'b1;
        ex = '{afecrb_pkg::RST_CONFIG, afecrb_pkg::RST_STANDBY,
               afecrb_pkg::RST_GAIN, afecrb_pkg::RST_GAIN,
               afecrb_pkg::RST_CLAMP, afecrb_pkg::RST_CLAMP,
               afecrb_pkg::RST_TEST, afecrb_pkg::RST_PROBE};
        mk = '{afecrb_pkg::MASK_CONFIG, afecrb_pkg::MASK_STANDBY,
               afecrb_pkg::MASK_GAIN, afecrb_pkg::MASK_GAIN,
               afecrb_pkg::MASK_CLAMP, afecrb_pkg::MASK_CLAMP,
               afecrb_pkg::MASK_TEST, afecrb_pkg::MASK_PROBE};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_ports;
        rd_all;
        $display("test reset values done");
        // symmetric patterns keep both edge codes equal
        foreach (mk[p]) if (p < 3) begin
            for (int a = 0; a < 8; a++)
                wr(CHIP, a[2:0], p == 0 ? 10'h3ff : p == 1 ? 10'h155 : 10'h2aa);
            chk_ports;
            rd_all;
            $display("test pattern %0d done", p);
        end
        wr(CHIP ^ 2'h1, 3'h4, 10'h0ab);
        chk_ports;
        wr(CHIP, 3'h6, 10'h000);
        wr(CHIP, 3'h7, 10'h000);
        `CHK("data path", 12'h5a4, dout)
        wr(CHIP, 3'h7, 10'h002);
        `CHK("probe lsb", 12'h5a5, dout)
        // the lsb must follow the clock pin, not sit at one
        converter_clock <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("probe low", 12'h5a4, dout)
        wr(CHIP, 3'h7, 10'h000);
        wr(CHIP, 3'h4, 10'h050);
        $display("test data path done");
        for (int c = 0; c < 4; c++) for (int s = 0; s < 2; s++) begin
            wr(CHIP, 3'h6, {4'h0, c[1:0], 1'b0, s[0], 2'h1});
            // sample settled values, as inside the loops below
            #1 lim = 0;
            do begin
                v = dout;
                @(posedge clk);
                #1 lim++;
            end while (lim < 300 && (v === dout ||
                       (s == 1 && dout !== 12'h120)));
            v = dout;
            run = 0;
            while (run < 300 && dout === v) begin
                @(posedge clk);
                #1 run++;
            end
            `CHK("interval", (s ? 8 : 2) << c, run)
            if (s == 0) `CHK("ramp", v + 12'h001, dout)
            else `CHK("stripe", 12'h120, v)
        end
        $display("test patterns done");
        summarize;
    end
endmodule
`default_nettype wire
